// ### rtl/sat_regs.svh
// Register addresses, field positions, reset values and divider counts
`ifndef SAT_REGS_SVH
`define SAT_REGS_SVH

`define SAT_ADDR_CTRL 8'h91
`define SAT_ADDR_RLL 8'h92
`define SAT_ADDR_RLH 8'h93
`define SAT_ADDR_CL 8'h94
`define SAT_ADDR_CH 8'h95

`define SAT_BIT_TFH 7
`define SAT_BIT_TFL 6
`define SAT_BIT_LEN 5
`define SAT_BIT_CEN 4
`define SAT_BIT_SPLIT 3
`define SAT_BIT_RUN 2
`define SAT_BIT_UNUSED 1
`define SAT_BIT_XCLK 0

`define SAT_RST_BYTE 8'h00
`define SAT_BYTE_MAX 8'hFF
`define SAT_WORD_MAX 16'hFFFF
`define SAT_UNMAPPED_READ 8'h00

`define SAT_DIV12_LAST 4'hB
`define SAT_EXT_DIV_LAST 3'h7

`endif

// ### rtl/sat_pkg.sv
// State types of the split auto-reload timer
package sat_pkg;

  typedef struct packed {
    logic [3:0] div12_cnt;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic [2:0] ext_cnt;
    logic tick12;
    logic tick8;
  } sat_tick_s;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic rise;
  } sat_edge_s;

  typedef struct packed {
    logic tfh;
    logic tfl;
    logic len;
    logic cen;
    logic split;
    logic run;
    logic xclk;
    logic [7:0] rll;
    logic [7:0] rlh;
    logic [7:0] cl;
    logic [7:0] ch;
    logic [7:0] rdata;
    logic irq;
  } sat_main_s;

endpackage

// ### rtl/sat_tick_gen.sv
// Count sources: system clock divided by 12 and synchronised external clock by 8
`timescale 1ns/1ps
`include "sat_regs.svh"

module sat_tick_gen (
  input wire logic clk,
  input wire logic srst,
  input wire logic ext_osc,
  output logic tick12,
  output logic tick8
);

  sat_pkg::sat_tick_s st;
  sat_pkg::sat_tick_s next_st;

  always_comb
  begin
    next_st = st;
    next_st.tick12 = 1'b0;
    next_st.tick8 = 1'b0;
    if (st.div12_cnt == `SAT_DIV12_LAST)
    begin
      next_st.div12_cnt = 4'h0;
      next_st.tick12 = 1'b1;
    end
    else
    begin
      next_st.div12_cnt = st.div12_cnt + 4'h1;
    end
    // External clock enters through two flops before any edge logic
    next_st.ext_s1 = ext_osc; // RULE9
    next_st.ext_s2 = st.ext_s1; // RULE9
    next_st.ext_s3 = st.ext_s2;
    if (st.ext_s2 && !st.ext_s3)
    begin
      next_st.ext_cnt = st.ext_cnt + 3'h1;
      if (st.ext_cnt == `SAT_EXT_DIV_LAST)
      begin
        next_st.tick8 = 1'b1; // RULE9
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign tick12 = st.tick12;
  assign tick8 = st.tick8;

endmodule

// ### rtl/sat_edge_sync.sv
// Synchroniser and rising-edge detector for the low-frequency oscillator
`timescale 1ns/1ps

module sat_edge_sync (
  input wire logic clk,
  input wire logic srst,
  input wire logic din,
  output logic rise
);

  sat_pkg::sat_edge_s st;
  sat_pkg::sat_edge_s next_st;

  always_comb
  begin
    next_st = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.rise = st.s2 & ~st.s3;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rise = st.rise;

endmodule

// ### rtl/sat_timer.sv
// Split auto-reload timer with register port and capture mode
// How it works
// RULE1: Split bit chooses one 16-bit counter or two 8-bit counters.
// RULE2: 16-bit wrap from all ones reloads both bytes and sets high flag.
// RULE3: With interrupts enabled, every full overflow requests an interrupt.
// RULE4: Low-byte wrap also interrupts when its own enable bit is set.
// RULE5: In split mode each byte reloads from its own reload byte.
// RULE6: Run bit gates whole timer, or only the high byte in split mode.
// RULE7: Per-byte select picks system clock, else divided or external source.
// RULE8: 16-bit mode counts system clock, clock by 12 or external by 8.
// RULE9: External by-8 source is synchronised to the system clock first.
// RULE10: High flag on high-byte wrap, low flag on low-byte wrap, any mode.
// RULE11: Split mode interrupts on high wrap, and low wrap when enabled.
// RULE12: Hardware never clears overflow flags; software clears them.
// RULE13: Software reads both flags to learn which byte interrupted.
// RULE14: Capture copies count into reload on oscillator rise and interrupts.
// RULE15: External select bit serves both bytes; per-byte select may override.
// RULE16: Control bit 1 always reads zero and ignores writes.
// RULE17: Count registers hold the 16-bit halves or the two 8-bit counts.
// RULE18: Enabled counters step once per tick; count writes take effect at once.
`timescale 1ns/1ps
`include "sat_regs.svh"

module sat_timer (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_WE,
  input wire logic SFR_RE,
  output logic [7:0] SFR_RDATA,
  input wire logic IRQ_ENABLE,
  input wire logic HIGH_CLK_SEL,
  input wire logic LOW_CLK_SEL,
  input wire logic EXT_OSC,
  input wire logic LFO_OUT,
  output logic IRQ
);

  sat_pkg::sat_main_s st;
  sat_pkg::sat_main_s next_st;

  logic tick12;
  logic tick8;
  logic lfo_rise;
  logic ext_src;
  logic tick_l;
  logic tick_h;
  logic wr_ctrl;
  logic wr_rll;
  logic wr_rlh;
  logic wr_cl;
  logic wr_ch;
  logic set_h;
  logic set_l;
  logic [15:0] count;
  logic [15:0] reload;

  sat_tick_gen u_tick (
    .clk(CLK),
    .srst(SRST),
    .ext_osc(EXT_OSC),
    .tick12(tick12),
    .tick8(tick8)
  );

  sat_edge_sync u_lfo (
    .clk(CLK),
    .srst(SRST),
    .din(LFO_OUT),
    .rise(lfo_rise)
  );

  assign count = {st.ch, st.cl};
  assign reload = {st.rlh, st.rll};
  assign wr_ctrl = SFR_WE && (SFR_ADDR == `SAT_ADDR_CTRL);
  assign wr_rll = SFR_WE && (SFR_ADDR == `SAT_ADDR_RLL);
  assign wr_rlh = SFR_WE && (SFR_ADDR == `SAT_ADDR_RLH);
  assign wr_cl = SFR_WE && (SFR_ADDR == `SAT_ADDR_CL);
  assign wr_ch = SFR_WE && (SFR_ADDR == `SAT_ADDR_CH);

  // One external select serves both bytes; each byte may take system clock
  assign ext_src = st.xclk ? tick8 : tick12; // RULE15 RULE8
  assign tick_l = LOW_CLK_SEL ? 1'b1 : ext_src; // RULE7 RULE8
  assign tick_h = HIGH_CLK_SEL ? 1'b1 : ext_src; // RULE7

  always_comb
  begin
    next_st = st;
    set_h = 1'b0;
    set_l = 1'b0;
    if (!st.split)
    begin
      // 16-bit mode: low byte select clocks the whole counter
      if (st.run && tick_l) // RULE6 RULE1
      begin
        if (count == `SAT_WORD_MAX)
        begin
          next_st.ch = st.rlh; // RULE2
          next_st.cl = st.rll; // RULE2
          set_h = 1'b1; // RULE2 RULE10
          set_l = 1'b1; // RULE10
        end
        else
        begin
          {next_st.ch, next_st.cl} = count + 16'h0001; // RULE18 RULE17
          set_l = (st.cl == `SAT_BYTE_MAX); // RULE10
        end
      end
    end
    else
    begin
      // Split mode: low byte always runs, high byte follows run bit
      if (tick_l) // RULE6 RULE1
      begin
        if (st.cl == `SAT_BYTE_MAX)
        begin
          next_st.cl = st.rll; // RULE5
          set_l = 1'b1; // RULE10
        end
        else
        begin
          next_st.cl = st.cl + 8'h01; // RULE18
        end
      end
      if (st.run && tick_h) // RULE6
      begin
        if (st.ch == `SAT_BYTE_MAX)
        begin
          next_st.ch = st.rlh; // RULE5
          set_h = 1'b1; // RULE10
        end
        else
        begin
          next_st.ch = st.ch + 8'h01; // RULE18
        end
      end
    end
    // Capture takes the count as it stood before this cycle's step
    if (st.cen && lfo_rise)
    begin
      next_st.rll = st.cl; // RULE14
      next_st.rlh = st.ch; // RULE14
      set_h = 1'b1; // RULE14
    end
    // Flags only set here; a write loads them from the data, but a new event wins
    if (wr_ctrl)
    begin
      next_st.tfh = SFR_WDATA[`SAT_BIT_TFH] | set_h; // RULE12
      next_st.tfl = SFR_WDATA[`SAT_BIT_TFL] | set_l; // RULE12
      next_st.len = SFR_WDATA[`SAT_BIT_LEN];
      next_st.cen = SFR_WDATA[`SAT_BIT_CEN];
      next_st.split = SFR_WDATA[`SAT_BIT_SPLIT];
      next_st.run = SFR_WDATA[`SAT_BIT_RUN];
      next_st.xclk = SFR_WDATA[`SAT_BIT_XCLK];
    end
    else
    begin
      next_st.tfh = st.tfh | set_h; // RULE12
      next_st.tfl = st.tfl | set_l; // RULE12
    end
    if (wr_rll)
    begin
      next_st.rll = SFR_WDATA;
    end
    if (wr_rlh)
    begin
      next_st.rlh = SFR_WDATA;
    end
    if (wr_cl)
    begin
      next_st.cl = SFR_WDATA; // RULE18
    end
    if (wr_ch)
    begin
      next_st.ch = SFR_WDATA; // RULE18
    end
    if (SFR_RE)
    begin
      unique case (SFR_ADDR)
        `SAT_ADDR_CTRL:
        begin
          next_st.rdata = {st.tfh, st.tfl, st.len, st.cen,
                           st.split, st.run, 1'b0, st.xclk}; // RULE16
        end
        `SAT_ADDR_RLL:
        begin
          next_st.rdata = st.rll;
        end
        `SAT_ADDR_RLH:
        begin
          next_st.rdata = st.rlh;
        end
        `SAT_ADDR_CL:
        begin
          next_st.rdata = st.cl; // RULE17
        end
        `SAT_ADDR_CH:
        begin
          next_st.rdata = st.ch; // RULE17
        end
        default:
        begin
          next_st.rdata = `SAT_UNMAPPED_READ;
        end
      endcase
    end
    // Request stands while an enabled flag stays set
    next_st.irq = IRQ_ENABLE &
                  (next_st.tfh | (next_st.tfl & next_st.len)); // RULE3 RULE4 RULE11
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign SFR_RDATA = st.rdata;
  assign IRQ = st.irq;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);

  logic no_cnt_wr;
  assign no_cnt_wr = !wr_cl && !wr_ch;

  sequence s_wrap16;
    !st.split && st.run && tick_l && (count == `SAT_WORD_MAX) &&
      no_cnt_wr && !(st.cen && lfo_rise) && !wr_rll && !wr_rlh;
  endsequence

  sequence s_reloaded16;
    (count == $past(reload)) && st.tfh && st.tfl;
  endsequence

  property p_wrap16;
    s_wrap16 |=> s_reloaded16;
  endproperty
  a_wrap16: assert property (p_wrap16) // RULE2
    else $error("16-bit wrap did not reload or flag");

  property p_irq_full;
    (IRQ_ENABLE && st.tfh && !wr_ctrl) |=> IRQ;
  endproperty
  a_irq_full: assert property (p_irq_full) // RULE3
    else $error("high flag set without interrupt");

  property p_irq_low;
    (IRQ_ENABLE && st.tfl && st.len && !wr_ctrl) |=> IRQ;
  endproperty
  a_irq_low: assert property (p_irq_low) // RULE4
    else $error("low flag enabled without interrupt");

  property p_irq_gate;
    !IRQ_ENABLE |=> !IRQ;
  endproperty
  a_irq_gate: assert property (p_irq_gate) // RULE11
    else $error("interrupt while timer interrupts disabled");

  sequence s_split_low_wrap;
    st.split && tick_l && (st.cl == `SAT_BYTE_MAX) && !wr_cl && !wr_rll &&
      !(st.cen && lfo_rise);
  endsequence

  property p_split_low;
    s_split_low_wrap |=> (st.cl == $past(st.rll)) && st.tfl;
  endproperty
  a_split_low: assert property (p_split_low) // RULE5
    else $error("split low byte did not reload");

  property p_split_hold;
    (st.split && !st.run && !wr_ch) |=> $stable(st.ch);
  endproperty
  a_split_hold: assert property (p_split_hold) // RULE6
    else $error("stopped high byte moved");

  property p_stop16;
    (!st.split && !st.run && no_cnt_wr) |=> $stable(count);
  endproperty
  a_stop16: assert property (p_stop16) // RULE6
    else $error("stopped 16-bit counter moved");

  property p_keep_flag;
    (st.tfh && !wr_ctrl) |=> st.tfh [*1];
  endproperty
  a_keep_flag: assert property (p_keep_flag) // RULE12
    else $error("high flag cleared by hardware");

  property p_capture;
    (st.cen && lfo_rise && !wr_rll && !wr_rlh) |=>
      (reload == $past(count)) && st.tfh;
  endproperty
  a_capture: assert property (p_capture) // RULE14
    else $error("capture did not copy count");

  property p_bit1;
    (SFR_RE && SFR_ADDR == `SAT_ADDR_CTRL) |=> !SFR_RDATA[`SAT_BIT_UNUSED];
  endproperty
  a_bit1: assert property (p_bit1) // RULE16
    else $error("unused control bit read as one");

  property p_step;
    (st.split && tick_l && st.cl != `SAT_BYTE_MAX && !wr_cl) |=>
      (st.cl == $past(st.cl) + 8'h01);
  endproperty
  a_step: assert property (p_step) // RULE18
    else $error("low byte did not step by one");

  // A reload value of all ones would leave the low byte unchanged on a wrap
  property p_system_clock_low;
    (LOW_CLK_SEL && st.split && !wr_cl && st.rll != `SAT_BYTE_MAX) [*2] |->
      (st.cl != $past(st.cl));
  endproperty
  a_system_clock_low: assert property (p_system_clock_low) // RULE7
    else $error("system clock select did not count");

  property p_split_high;
    (st.split && st.run && tick_h && st.ch == `SAT_BYTE_MAX && !wr_ch &&
      IRQ_ENABLE) |=> (st.ch == $past(st.rlh)) && IRQ;
  endproperty
  a_split_high: assert property (p_split_high) // RULE11
    else $error("split high byte wrap did not reload or interrupt");

  property p_keep_low_flag;
    (st.tfl && !wr_ctrl) |=> st.tfl;
  endproperty
  a_keep_low_flag: assert property (p_keep_low_flag) // RULE12
    else $error("low flag cleared by hardware");

endmodule

// ### verification/tb_top.sv
// Self-checking bench for the split auto-reload timer
`timescale 1ns/1ps
`include "sat_regs.svh"

module tb_top;
  logic CLK = 1'b0;
  logic SRST = 1'b1;
  logic [7:0] SFR_ADDR = 8'h00;
  logic [7:0] SFR_WDATA = 8'h00;
  logic SFR_WE = 1'b0;
  logic SFR_RE = 1'b0;
  logic [7:0] SFR_RDATA;
  logic IRQ_ENABLE = 1'b0;
  logic HIGH_CLK_SEL = 1'b1;
  logic LOW_CLK_SEL = 1'b1;
  logic EXT_OSC = 1'b0;
  logic LFO_OUT = 1'b0;
  logic IRQ;
  logic [7:0] lfsr_q = 8'h22;
  logic [7:0] a;
  int mismatches = 0;
  int samples_checked = 0;
  int ext_div = 0;
  int mirror [int];

  sat_timer i_dut (
    .CLK(CLK),
    .SRST(SRST),
    .SFR_ADDR(SFR_ADDR),
    .SFR_WDATA(SFR_WDATA),
    .SFR_WE(SFR_WE),
    .SFR_RE(SFR_RE),
    .SFR_RDATA(SFR_RDATA),
    .IRQ_ENABLE(IRQ_ENABLE),
    .HIGH_CLK_SEL(HIGH_CLK_SEL),
    .LOW_CLK_SEL(LOW_CLK_SEL),
    .EXT_OSC(EXT_OSC),
    .LFO_OUT(LFO_OUT),
    .IRQ(IRQ)
  );

  always #5 CLK = ~CLK;

  // External oscillator: one rise every 6 system clocks
  always @(posedge CLK)
  begin
    ext_div <= (ext_div == 2) ? 0 : ext_div + 1;
    if (ext_div == 2)
      EXT_OSC <= ~EXT_OSC;
  end

  function automatic logic [7:0] lfsr_next(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_irq(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge CLK);
    SFR_ADDR <= ad;
    SFR_WDATA <= d;
    SFR_WE <= 1'b1;
    @(posedge CLK);
    SFR_WE <= 1'b0;
    mirror[ad] = d;
  endtask

  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    @(posedge CLK);
    SFR_ADDR <= ad;
    SFR_RE <= 1'b1;
    @(posedge CLK);
    SFR_RE <= 1'b0;
    @(posedge CLK);
    d = SFR_RDATA;
  endtask

  // Count advance over m cycles, taken from two reads m cycles apart
  task automatic rate(input logic [7:0] ad, input int m, input int n);
    logic [7:0] p;
    logic [7:0] q;
    rd(ad, p);
    repeat (m - 3) @(posedge CLK);
    rd(ad, q);
    chk(q - p, n[7:0]);
  endtask

  task automatic stop_test;
    $display("mismatches %0d samples_checked %0d", mismatches,
             samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    #100000;
    mismatches++;
    stop_test();
  end

  initial
  begin
    repeat (20) @(posedge CLK);
    SRST <= 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      rd(8'h91 + i[7:0], a);
      chk(a, `SAT_RST_BYTE);
    end
    wr(`SAT_ADDR_CTRL, 8'h02);
    rd(`SAT_ADDR_CTRL, a);
    chk(a, 8'h00);
    wr(8'h96, 8'h5A);
    rd(8'h96, a);
    chk(a, `SAT_UNMAPPED_READ);
    for (int i = 0; i < 4; i++)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      wr(`SAT_ADDR_RLL + i[7:0] % 2, lfsr_q);
      rd(`SAT_ADDR_RLL + i[7:0] % 2, a);
      chk(a, mirror[`SAT_ADDR_RLL + i % 2]);
    end
    // 16-bit mode, system clock then clock by 12, overflow and reload
    IRQ_ENABLE <= 1'b1;
    wr(`SAT_ADDR_RLL, 8'h34);
    wr(`SAT_ADDR_RLH, 8'h12);
    wr(`SAT_ADDR_CTRL, 8'h04);
    rate(`SAT_ADDR_CL, 20, 20);
    wr(`SAT_ADDR_CL, 8'hF0);
    wr(`SAT_ADDR_CH, 8'hFF);
    repeat (30) @(posedge CLK);
    rd(`SAT_ADDR_CH, a);
    chk(a, 8'h12);
    rd(`SAT_ADDR_CTRL, a);
    chk(a, 8'hC4);
    chk_irq(IRQ, 1'b1);
    wr(`SAT_ADDR_CTRL, 8'h64);
    repeat (3) @(posedge CLK);
    chk_irq(IRQ, 1'b1);
    wr(`SAT_ADDR_CTRL, 8'h04);
    repeat (3) @(posedge CLK);
    chk_irq(IRQ, 1'b0);
    wr(`SAT_ADDR_CTRL, 8'h24);
    repeat (260) @(posedge CLK);
    chk_irq(IRQ, 1'b1);
    rd(`SAT_ADDR_CTRL, a);
    chk(a, 8'h64);
    IRQ_ENABLE <= 1'b0;
    repeat (3) @(posedge CLK);
    chk_irq(IRQ, 1'b0);
    LOW_CLK_SEL <= 1'b0;
    wr(`SAT_ADDR_CL, 8'h00);
    rate(`SAT_ADDR_CL, 120, 10);
    // Split mode: low byte runs with run bit clear
    LOW_CLK_SEL <= 1'b1;
    wr(`SAT_ADDR_CTRL, 8'h08);
    wr(`SAT_ADDR_CH, 8'h55);
    wr(`SAT_ADDR_CL, 8'hF0);
    wr(`SAT_ADDR_RLL, 8'hA0);
    repeat (40) @(posedge CLK);
    rd(`SAT_ADDR_CH, a);
    chk(a, 8'h55);
    rd(`SAT_ADDR_CTRL, a);
    chk(a, 8'h48);
    rd(`SAT_ADDR_CL, a);
    chk({7'h00, a >= 8'hA0 && a < 8'hF0}, 8'h01);
    IRQ_ENABLE <= 1'b1;
    wr(`SAT_ADDR_CTRL, 8'h0C);
    wr(`SAT_ADDR_RLH, 8'h77);
    wr(`SAT_ADDR_CH, 8'hFE);
    repeat (10) @(posedge CLK);
    rd(`SAT_ADDR_CH, a);
    chk(a, 8'h80);
    chk_irq(IRQ, 1'b1);
    rd(`SAT_ADDR_CTRL, a);
    chk({7'h00, a[`SAT_BIT_TFH]}, 8'h01);
    // Split mode sources: low on divided clocks, high on system clock then external by 8
    LOW_CLK_SEL <= 1'b0;
    rate(`SAT_ADDR_CL, 120, 10);
    wr(`SAT_ADDR_CTRL, 8'h0D);
    rate(`SAT_ADDR_CL, 480, 10);
    wr(`SAT_ADDR_CH, 8'h00);
    rate(`SAT_ADDR_CH, 20, 20);
    HIGH_CLK_SEL <= 1'b0;
    rate(`SAT_ADDR_CH, 480, 10);
    // Capture of a stopped count on an oscillator rise
    wr(`SAT_ADDR_CTRL, 8'h10);
    lfsr_q = lfsr_next(lfsr_q);
    wr(`SAT_ADDR_CL, lfsr_q);
    lfsr_q = lfsr_next(lfsr_q);
    wr(`SAT_ADDR_CH, lfsr_q);
    @(posedge CLK);
    LFO_OUT <= 1'b1;
    repeat (10) @(posedge CLK);
    LFO_OUT <= 1'b0;
    rd(`SAT_ADDR_RLL, a);
    chk(a, mirror[`SAT_ADDR_CL]);
    rd(`SAT_ADDR_RLH, a);
    chk(a, mirror[`SAT_ADDR_CH]);
    rd(`SAT_ADDR_CH, a);
    chk(a, mirror[`SAT_ADDR_CH]);
    rd(`SAT_ADDR_CTRL, a);
    chk(a, 8'h90);
    chk_irq(IRQ, 1'b1);
    stop_test();
  end
endmodule
